// ---- rtl/xcmp_pkg.sv ----
/*
  shared constants and carriers for the extended compare datapath and system counter.
  assumes a single system clock; decode logic outside supplies operands and effect selections.
*/
`default_nettype none
package xcmp_pkg;
  // ----------------------------------------
  // widths and encodings
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int INSTR_W = 6;
  localparam int ADDR_W = 9;
  localparam int IMM_W = 9;
  localparam logic [INSTR_W-1:0] OP_CMP_UNSIGNED_EXT = 6'h33;
  // signed variant opcode is not given; parameterised default is arbitrary
  localparam logic [INSTR_W-1:0] OP_CMP_SIGNED_EXT_DEFAULT = 6'h31;
  localparam logic [ADDR_W-1:0] TIME_COUNT_ADDR_DEFAULT = 9'h100;
  localparam logic [WORD_W-1:0] TIME_COUNT_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] TIME_COUNT_STEP = 32'h0000_0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] opcode;
    logic imm_sel;
    logic [IMM_W-1:0] imm;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [WORD_W-1:0] src_reg;
    logic [WORD_W-1:0] dst_reg;
    logic zero_in;
    logic carry_in;
    logic update_zero_flag_effect;
    logic update_carry_flag_effect;
    logic write_result_effect;
  } xcmp_req_t;

  typedef struct packed {
    logic valid;
    logic zero;
    logic carry;
    logic result_write;
    logic [ADDR_W-1:0] result_addr;
    logic [WORD_W-1:0] result;
    logic shadow_hit;
  } xcmp_rsp_t;
endpackage
`default_nettype wire

// ---- rtl/global_time_count.sv ----
/*
  free-running global 32-bit system counter.
  assumes one system clock shared with every core.
*/
`timescale 1ns/1ps
`default_nettype none
module global_time_count #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // count value
  output logic [WIDTH-1:0] COUNT
);
  import xcmp_pkg::*;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COUNT <= WIDTH'(TIME_COUNT_RESET);
    end else begin
      COUNT <= COUNT + WIDTH'(TIME_COUNT_STEP);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/extended_compare_and_sys_counter.sv ----
/*
  extended unsigned and signed compare datapath with flag chaining, plus the shared system counter.
  assumes the core decode supplies register operands, incoming flags and effect selections in one
  cycle; results, flags and the shadow register at the counter address are returned registered.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - opcode 110011 selects the unsigned extended compare including incoming carry
// - source is a register or the 9-bit immediate from the source field
// - unsigned variant treats both operands as unsigned 32-bit values
// - compare is destination minus source minus carry; flags kept, result optional
// - destination unchanged unless result writing is selected
// - written result is destination minus source minus carry, wrapped to 32 bits
// - zero and carry change only under their own write effects
// - unsigned: zero set only if zero was set and destination equals source plus carry
// - unsigned: carry set when destination below source plus carry, unsigned chained
// - unsigned: 0x80000000 against 0x7fffffff with carry clear clears carry
// - signed: zero set only if zero was set and destination equals source plus carry
// - signed: carry set when destination below source plus carry, two's complement
// - one global 32-bit counter shared by all cores, incrementing every clock
// - counter address as source operand delivers the current count
// - counter address as destination touches a shadow register, not the counter
module extended_compare_and_sys_counter #(
  parameter logic [xcmp_pkg::INSTR_W-1:0] OP_CMP_SIGNED_EXT = xcmp_pkg::OP_CMP_SIGNED_EXT_DEFAULT,
  parameter logic [xcmp_pkg::ADDR_W-1:0] TIME_COUNT_ADDR = xcmp_pkg::TIME_COUNT_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // instruction request
  input wire xcmp_pkg::xcmp_req_t REQ,
  // instruction answer
  output xcmp_pkg::xcmp_rsp_t RSP,
  // counter and shadow visibility
  output logic [xcmp_pkg::WORD_W-1:0] TIME_COUNT,
  output logic [xcmp_pkg::WORD_W-1:0] SHADOW
);
  import xcmp_pkg::*;

  // ----------------------------------------
  // system counter
  // ----------------------------------------
  logic [WORD_W-1:0] count_value;

  global_time_count #(
    .WIDTH(WORD_W)
  ) u_count (
    .CLK(CLK),
    .RST_N(RST_N),
    .COUNT(count_value)
  );

  assign TIME_COUNT = count_value;

  // ----------------------------------------
  // decode and arithmetic helpers
  // ----------------------------------------
  // one opcode against one compare code
  function automatic logic opcode_hit(input logic [INSTR_W-1:0] op,
                                      input logic [INSTR_W-1:0] code);
    opcode_hit = (op == code);
  endfunction

  // register address that aliases the system counter
  function automatic logic at_count_addr(input logic [ADDR_W-1:0] addr);
    at_count_addr = (addr == TIME_COUNT_ADDR);
  endfunction

  // immediate literal widened to a full word
  function automatic logic [WORD_W-1:0] widen_imm(input logic [IMM_W-1:0] imm);
    widen_imm = {{(WORD_W-IMM_W){1'b0}}, imm};
  endfunction

  // destination minus source minus carry, borrow in the top bit
  function automatic logic [WORD_W:0] sub_with_borrow(input logic [WORD_W-1:0] d,
                                                     input logic [WORD_W-1:0] s,
                                                     input logic c);
    sub_with_borrow = {1'b0, d} - {1'b0, s} - {{WORD_W{1'b0}}, c};
  endfunction

  // two's-complement ordering from the unsigned borrow and both signs
  function automatic logic two_comp_less(input logic borrow,
                                         input logic d_sign,
                                         input logic s_sign);
    two_comp_less = borrow ^ d_sign ^ s_sign;
  endfunction

  // chained equality: earlier words equal and nothing left in this one
  function automatic logic chained_equal(input logic zero_before,
                                         input logic [WORD_W:0] d);
    chained_equal = zero_before && (d == {1'b0, WORD_ZERO});
  endfunction

  // ----------------------------------------
  // operand selection
  // ----------------------------------------
  logic [WORD_W-1:0] shadow_reg;
  logic [WORD_W-1:0] src_value;
  logic [WORD_W-1:0] dst_value;
  logic is_unsigned;
  logic is_signed;
  logic compare_hit;
  logic src_is_count;
  logic dst_is_shadow;

  always_comb begin
    is_unsigned = 1'b0;
    is_signed = 1'b0;
    if (REQ.valid) begin
      if (opcode_hit(REQ.opcode, OP_CMP_UNSIGNED_EXT)) begin
        is_unsigned = 1'b1;
      end else if (opcode_hit(REQ.opcode, OP_CMP_SIGNED_EXT)) begin
        is_signed = 1'b1;
      end
    end
  end

  assign compare_hit = is_unsigned || is_signed;
  assign src_is_count = !REQ.imm_sel && at_count_addr(REQ.src_addr);
  assign dst_is_shadow = at_count_addr(REQ.dst_addr);

  // immediate wins over any register address
  always_comb begin
    if (REQ.imm_sel) begin
      src_value = widen_imm(REQ.imm);
    end else if (src_is_count) begin
      src_value = count_value;
    end else begin
      src_value = REQ.src_reg;
    end
  end

  // destination at the counter address reads the shadow, never the counter
  always_comb begin
    if (dst_is_shadow) begin
      dst_value = shadow_reg;
    end else begin
      dst_value = REQ.dst_reg;
    end
  end

  // ----------------------------------------
  // subtraction and flags
  // ----------------------------------------
  logic [WORD_W:0] diff;
  logic [WORD_W-1:0] next_result;
  logic borrow_unsigned;
  logic less_signed;
  logic equal_chain;
  logic next_carry;
  logic next_zero;

  assign diff = sub_with_borrow(dst_value, src_value, REQ.carry_in);
  assign next_result = diff[WORD_W-1:0];
  // unsigned ordering: borrow out of the extended subtraction
  assign borrow_unsigned = diff[WORD_W];
  // signed ordering: flip the borrow when the operand signs differ
  assign less_signed = two_comp_less(diff[WORD_W], dst_value[WORD_W-1], src_value[WORD_W-1]);
  assign equal_chain = chained_equal(REQ.zero_in, diff);

  always_comb begin
    next_carry = REQ.carry_in;
    if (REQ.update_carry_flag_effect) begin
      if (is_signed) begin
        next_carry = less_signed;
      end else begin
        next_carry = borrow_unsigned;
      end
    end
  end

  always_comb begin
    next_zero = REQ.zero_in;
    if (REQ.update_zero_flag_effect) begin
      next_zero = equal_chain;
    end
  end

  // ----------------------------------------
  // answer next values
  // ----------------------------------------
  logic next_result_write;
  logic next_shadow_hit;
  logic [WORD_W-1:0] next_answer_word;

  // a write aimed at the counter address lands in the shadow instead
  always_comb begin
    next_result_write = 1'b0;
    next_shadow_hit = 1'b0;
    if (compare_hit && REQ.write_result_effect) begin
      if (dst_is_shadow) begin
        next_shadow_hit = 1'b1;
      end else begin
        next_result_write = 1'b1;
      end
    end
  end

  always_comb begin
    if (REQ.write_result_effect) begin
      next_answer_word = next_result;
    end else begin
      next_answer_word = dst_value;
    end
  end

  // ----------------------------------------
  // registered answer
  // ----------------------------------------
  logic answer_valid;
  logic zero_flag;
  logic carry_flag;
  logic result_write;
  logic shadow_hit;
  logic [ADDR_W-1:0] result_addr;
  logic [WORD_W-1:0] result_word;

  // answer strobe, one cycle after each compare
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      answer_valid <= 1'b0;
    end else begin
      answer_valid <= compare_hit;
    end
  end

  // flags hold between compares
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      zero_flag <= 1'b0;
    end else if (compare_hit) begin
      zero_flag <= next_zero;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      carry_flag <= 1'b0;
    end else if (compare_hit) begin
      carry_flag <= next_carry;
    end
  end

  // write strobes last one cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_write <= 1'b0;
    end else begin
      result_write <= next_result_write;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shadow_hit <= 1'b0;
    end else begin
      shadow_hit <= next_shadow_hit;
    end
  end

  // destination address and answer word hold between compares
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_addr <= '0;
    end else if (compare_hit) begin
      result_addr <= REQ.dst_addr;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_word <= WORD_ZERO;
    end else if (compare_hit) begin
      result_word <= next_answer_word;
    end
  end

  // answer port built from the registers above
  always_comb begin
    RSP = '0;
    RSP.valid = answer_valid;
    RSP.zero = zero_flag;
    RSP.carry = carry_flag;
    RSP.result_write = result_write;
    RSP.result_addr = result_addr;
    RSP.result = result_word;
    RSP.shadow_hit = shadow_hit;
  end

  // ----------------------------------------
  // shadow register at the counter address
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shadow_reg <= WORD_ZERO;
    end else if (next_shadow_hit) begin
      shadow_reg <= next_result;
    end
  end

  assign SHADOW = shadow_reg;
endmodule
`default_nettype wire

// ---- testbench/xcmp_checker_props.sv ----
/* port assertions for the compare datapath and counter; bound to the top module */
`timescale 1ns/1ps
`default_nettype none
module xcmp_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire xcmp_pkg::xcmp_req_t REQ,
  input wire xcmp_pkg::xcmp_rsp_t RSP,
  input wire logic [31:0] TIME_COUNT,
  input wire logic [31:0] SHADOW
);
  import xcmp_pkg::*;
  logic cmp, plain, ubor;
  logic [31:0] diff;
  logic [32:0] sdiff;
  assign cmp = REQ.valid && (REQ.opcode == OP_CMP_UNSIGNED_EXT || REQ.opcode == OP_CMP_SIGNED_EXT_DEFAULT);
  assign plain = cmp && !REQ.imm_sel && REQ.src_addr != TIME_COUNT_ADDR_DEFAULT && REQ.dst_addr != TIME_COUNT_ADDR_DEFAULT;
  assign ubor = {1'b0, REQ.dst_reg} < REQ.src_reg + 33'(REQ.carry_in);
  assign diff = REQ.dst_reg - REQ.src_reg - 32'(REQ.carry_in);
  assign sdiff = {REQ.dst_reg[31], REQ.dst_reg} - {REQ.src_reg[31], REQ.src_reg} - 33'(REQ.carry_in);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_uns;
    plain && REQ.opcode == OP_CMP_UNSIGNED_EXT;
  endsequence
  sequence s_sgn;
    plain && REQ.opcode == OP_CMP_SIGNED_EXT_DEFAULT;
  endsequence
  a_count_step: assert property ($past(RST_N) |-> TIME_COUNT == $past(TIME_COUNT) + 32'h1)
    else $error("count step");
  a_answer_next: assert property (s_uns |=> RSP.valid) else $error("no answer");
  a_idle_quiet: assert property (!REQ.valid |=> !RSP.valid && !RSP.result_write) else $error("stray answer");
  a_no_write: assert property (cmp && !REQ.write_result_effect |=> !RSP.result_write) else $error("write");
  a_zero_keep: assert property (cmp && !REQ.update_zero_flag_effect |=> RSP.zero == $past(REQ.zero_in))
    else $error("zero kept");
  a_carry_keep: assert property (cmp && !REQ.update_carry_flag_effect |=> RSP.carry == $past(REQ.carry_in))
    else $error("carry kept");
  a_zero_chain: assert property (cmp && REQ.update_zero_flag_effect && !REQ.zero_in |=> !RSP.zero)
    else $error("zero chain");
  a_carry_uns: assert property (s_uns ##0 REQ.update_carry_flag_effect |=> RSP.carry == $past(ubor))
    else $error("carry");
  a_result_wr: assert property (s_uns ##0 REQ.write_result_effect |=> RSP.result_write && RSP.result == $past(diff))
    else $error("result");
  a_shadow_hold: assert property (!REQ.valid |=> $stable(SHADOW)) else $error("shadow");
  a_carry_sgn: assert property (s_sgn ##0 REQ.update_carry_flag_effect |=> RSP.carry == $past(sdiff[32]))
    else $error("signed carry");
  a_shadow_write: assert property (cmp && REQ.write_result_effect && REQ.dst_addr == TIME_COUNT_ADDR_DEFAULT |=>
    RSP.shadow_hit && !RSP.result_write) else $error("shadow write");
endmodule
bind extended_compare_and_sys_counter xcmp_checker xcmp_checker_inst (.CLK(CLK), .RST_N(RST_N), .REQ(REQ),
  .RSP(RSP), .TIME_COUNT(TIME_COUNT), .SHADOW(SHADOW));
`default_nettype wire

// ---- testbench/core_flag_chain.sv ----
/* core side flag keeper: chains zero and carry between words; fed by the answer port */
`timescale 1ns/1ps
`default_nettype none
module core_flag_chain (
  input wire logic CLK,
  input wire logic RST_N,
  input wire xcmp_pkg::xcmp_rsp_t RSP,
  output logic zero,
  output logic carry
);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      zero <= 1'b1;
      carry <= 1'b0;
    end else if (RSP.valid) begin
      zero <= RSP.zero;
      carry <= RSP.carry;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/extended_compare_and_sys_counter_test.sv ----
/* self-checking bench for the compare datapath; needs the design, checker and flag keeper */
`timescale 1ns/1ps
`default_nettype none
module extended_compare_and_sys_counter_test;
  import xcmp_pkg::*;
  typedef struct packed {logic [31:0] d, s; logic zi, ci; logic [31:0] r; logic zo, co;} row_t;
  logic CLK = 0, RST_N = 0, fz, fc;
  xcmp_req_t REQ = '0, base = '0;
  xcmp_rsp_t RSP;
  logic [31:0] TIME_COUNT, SHADOW, t;
  int bad_count = 0, n_tests = 0, cyc = 0;
  row_t rows [9] = '{'{32'h3, 32'h2, 1, 0, 32'h1, 0, 0}, '{32'h3, 32'h2, 1, 1, 32'h0, 1, 0},
    '{32'h3, 32'h3, 0, 0, 32'h0, 0, 0}, '{32'h3, 32'h3, 1, 0, 32'h0, 1, 0}, '{32'h3, 32'h3, 1, 1, 32'hffffffff, 0, 1},
    '{32'h3, 32'h4, 1, 1, 32'hfffffffe, 0, 1}, '{32'h80000000, 32'h7fffffff, 0, 0, 32'h1, 0, 0},
    '{32'h7fffffff, 32'h80000000, 0, 0, 32'hffffffff, 0, 1}, '{32'hfffffffe, 32'hfffffffd, 1, 1, 32'h0, 1, 0}};
  extended_compare_and_sys_counter extended_compare_and_sys_counter_inst (.CLK(CLK), .RST_N(RST_N), .REQ(REQ),
    .RSP(RSP), .TIME_COUNT(TIME_COUNT), .SHADOW(SHADOW));
  core_flag_chain core_flag_chain_inst (.CLK(CLK), .RST_N(RST_N), .RSP(RSP), .zero(fz), .carry(fc));
  initial forever #20 CLK = ~CLK;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task go(input logic [5:0] op, input logic [31:0] d, input logic [31:0] s, input logic zi, input logic ci,
    input logic [2:0] eff);
    @(posedge CLK) #1;
    REQ = base;
    REQ.valid = 1;
    REQ.opcode = op;
    REQ.dst_reg = d;
    REQ.src_reg = s;
    REQ.zero_in = zi;
    REQ.carry_in = ci;
    {REQ.update_zero_flag_effect, REQ.update_carry_flag_effect, REQ.write_result_effect} = eff;
    @(posedge CLK) #1;
    REQ.valid = 0;
  endtask
  task give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge CLK);
    #1 chk(TIME_COUNT, 32'h0);
    chk(RSP.valid, 0);
    repeat (3) @(posedge CLK);
    #1 RST_N = 1;
    foreach (rows[i]) begin
      go(OP_CMP_UNSIGNED_EXT, rows[i].d, rows[i].s, rows[i].zi, rows[i].ci, 3'b111);
      chk(RSP.result_write, 1);
      chk(RSP.result, rows[i].r);
      chk({RSP.zero, RSP.carry}, {rows[i].zo, rows[i].co});
    end
    go(OP_CMP_SIGNED_EXT_DEFAULT, 32'h80000000, 32'h7fffffff, 0, 0, 3'b111);
    chk(RSP.carry, 1);
    go(OP_CMP_SIGNED_EXT_DEFAULT, 32'h7fffffff, 32'h80000000, 1, 0, 3'b110);
    chk({RSP.zero, RSP.carry, RSP.result_write}, 3'b000);
    go(OP_CMP_UNSIGNED_EXT, 32'h3, 32'h4, 1, 1, 3'b000);
    chk({RSP.valid, RSP.zero, RSP.carry, RSP.result_write}, 4'he);
    chk(RSP.result, 32'h3);
    go(OP_CMP_UNSIGNED_EXT, 32'h0, 32'h1, 1, 0, 3'b110);
    chk({RSP.zero, RSP.carry}, 2'b01);
    @(posedge CLK) #1;
    go(OP_CMP_UNSIGNED_EXT, 32'h1, 32'h1, fz, fc, 3'b110);
    chk({RSP.zero, RSP.carry}, 2'b01);
    base.imm_sel = 1;
    base.imm = 9'h1ff;
    go(OP_CMP_UNSIGNED_EXT, 32'h1ff, 32'hffffffff, 1, 0, 3'b110);
    chk({RSP.zero, RSP.carry}, 2'b10);
    base = '0;
    base.src_addr = TIME_COUNT_ADDR_DEFAULT;
    go(OP_CMP_UNSIGNED_EXT, TIME_COUNT + 32'h1, 32'h0, 1, 0, 3'b100);
    chk(RSP.zero, 1);
    base = '0;
    base.dst_addr = TIME_COUNT_ADDR_DEFAULT;
    t = TIME_COUNT;
    go(OP_CMP_UNSIGNED_EXT, 32'h100, 32'h5, 1, 0, 3'b001);
    chk(SHADOW, 32'hfffffffb);
    chk({RSP.result_write, RSP.shadow_hit}, 2'b01);
    chk(RSP.result_addr, 32'(TIME_COUNT_ADDR_DEFAULT));
    chk(TIME_COUNT, t + 32'h2);
    RST_N = 0;
    @(posedge CLK) #1;
    chk(SHADOW, 32'h0);
    chk(TIME_COUNT, 32'h0);
    RST_N = 1;
    @(posedge CLK) #1;
    chk(TIME_COUNT, 32'h1);
    chk(RSP.valid, 0);
    give_verdict;
  end
endmodule
`default_nettype wire
